// ===== src/clkss_pkg.sv
// clkss_pkg: constants and types of the system clock source select block
package clkss_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int OST_W = 11;
  localparam int PS_W = 9;
  localparam logic [OST_W-1:0] OST_LAST = 11'h3FF;

  // ****************************************
  // source codes
  // ****************************************
  typedef enum logic [2:0] {
    SRC_HF2X = 3'h0,
    SRC_RSV1 = 3'h1,
    SRC_EXT4X = 3'h2,
    SRC_RSV3 = 3'h3,
    SRC_SECONDARY_OSC = 3'h4,
    SRC_LF = 3'h5,
    SRC_HF = 3'h6,
    SRC_EXT = 3'h7
  } clkss_src_t;

  typedef enum logic [1:0] {
    XM_EC = 2'h0,
    XM_LOW = 2'h1,
    XM_MID = 2'h2,
    XM_HIGH = 2'h3
  } clkss_xmode_t;

  // ****************************************
  // divider, frequency, trim
  // ****************************************
  localparam logic [3:0] DIV_ONE = 4'h1;
  localparam logic [3:0] DIV_MAX = 4'h9;
  localparam logic [3:0] DIV_RST_HF = 4'h2;
  localparam logic [3:0] DIV_RST_DEF = 4'h0;
  localparam logic [2:0] FRQ_8M = 3'h4;
  localparam logic [2:0] FRQ_12M = 3'h5;
  localparam logic [2:0] FRQ_16M = 3'h6;
  localparam logic [2:0] FRQ_RST_DEF = 3'h3;
  localparam logic [5:0] TRIM_RST = 6'h00;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_REQ = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CUR = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] REG_RDY = 4'h3;
  localparam logic [ADDR_W-1:0] REG_FRQ = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TRIM = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MEN = 4'h6;
  localparam int SRC_LSB = 4;
  localparam int CTL_HOLD = 0;
  localparam int CTL_NSR = 1;
  localparam int CTL_OSC_READY_FLAG = 2;
  localparam int CTL_SWIF = 3;
  localparam int RDY_EXT = 0;
  localparam int RDY_HF = 1;
  localparam int RDY_LF = 2;
  localparam int RDY_SECONDARY_OSC = 3;
  localparam int RDY_PLL = 4;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ext;
    logic hf;
    logic lf;
    logic secondary_osc;
    logic pll4x;
    logic pll2x;
  } clkss_osc_en_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_WAIT = 2'h1,
    SW_HOLD = 2'h2,
    SW_SWITCH = 2'h3
  } clkss_sw_t;
endpackage

// ===== src/clkss_startup.sv
// clkss_startup: crystal start-up counter on the crystal input
`timescale 1ns/1ns
module clkss_startup (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // control
  input wire logic restart_i,
  input wire logic run_i,
  input wire logic xtal_lvl_i,
  // status
  output logic done_o
);
  typedef struct packed {
    logic [clkss_pkg::OST_W-1:0] cnt;
    logic prev;
    logic done;
  } clkss_ost_st_t;

  clkss_ost_st_t st_reg;
  clkss_ost_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.prev = xtal_lvl_i;
    if (restart_i) begin
      st_next.cnt = '0;
      st_next.done = 1'b0;
    end else if (run_i && !st_reg.done && xtal_lvl_i && !st_reg.prev) begin
      if (st_reg.cnt == clkss_pkg::OST_LAST) begin
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_o = st_reg.done;

  ost_full_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(st_reg.done) |-> $past(st_reg.cnt) == clkss_pkg::OST_LAST)
    else $error("start-up done before full count");
endmodule // clkss_startup

// ===== src/clkss_glitchless.sv
// clkss_glitchless: source multiplexer that changes only while both clocks are low
`timescale 1ns/1ns
module clkss_glitchless (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire clkss_pkg::clkss_src_t rst_sel_i,
  // request
  input wire clkss_pkg::clkss_src_t req_sel_i,
  input wire logic go_i,
  input wire logic [7:0] src_lvl_i,
  // result
  output clkss_pkg::clkss_src_t cur_sel_o,
  output logic done_o,
  output logic clk_lvl_o
);
  typedef struct packed {
    clkss_pkg::clkss_src_t sel;
    logic done;
    logic lvl;
  } clkss_mux_st_t;

  clkss_mux_st_t st_reg;
  clkss_mux_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.lvl = src_lvl_i[st_reg.sel];
    if (go_i && !st_reg.done && !src_lvl_i[st_reg.sel] && !src_lvl_i[req_sel_i]) begin
      st_next.sel = req_sel_i;
      st_next.done = 1'b1;
      st_next.lvl = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_reg.sel <= rst_sel_i;
      st_reg.done <= 1'b0;
      st_reg.lvl <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cur_sel_o = st_reg.sel;
  assign done_o = st_reg.done;
  assign clk_lvl_o = st_reg.lvl;

  mux_low_change_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $changed(st_reg.sel) |-> !$past(src_lvl_i[st_reg.sel]) && !$past(src_lvl_i[req_sel_i]))
    else $error("source changed while a clock was high");
endmodule // clkss_glitchless

// ===== src/clkss_top.sv
// clkss_top: system clock source selection and control
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
// Functional notes
// - hold system clock until 1024 crystal edges
// - reset codes 110 and 000 start fast oscillator
// - postscaler divides one to 512
// - doubling PLL only for 8/12/16 MHz
// - code 000 sets 16 MHz, doubling PLL on
// - request 000 enables doubling PLL
// - trim resets zero, six-bit unsigned
// - trim 3Fh maximum, 0h minimum
// - trim write raises no flag
// - trim never touches slow oscillator
// - slow oscillator ticks timers regardless
// - separate ready bit per oscillator
// - manual enables without selecting
// - six selectable run-time sources
// - external with 4x PLL by reset/request
// - crystal out pin: clock or general purpose
// - secondary oscillator selectable at run time
// - gain select follows crystal mode while external is current or requested
// - fast oscillator frequency from select field
// - reset takes source from reset select
// - switch waits ready, then sets flags
// - hold defers switch; copy current abandons
// - switch updates current, ready flag set
// - reserved request code selects fast oscillator
module clkss_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [clkss_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [clkss_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [clkss_pkg::DATA_W-1:0] reg_rdata_o,
  // configuration
  input wire logic [2:0] reset_source_select_i,
  input wire logic [1:0] crystal_mode_i,
  input wire logic clock_out_pin_enable_i,
  input wire logic wake_i,
  // oscillators
  input wire logic [4:0] osc_ready_i,
  input wire logic [7:0] src_clk_lvl_i,
  input wire logic crystal_in_pin_i,
  output clkss_pkg::clkss_osc_en_t osc_enable_o,
  output logic [1:0] gain_select_o,
  output logic [2:0] fast_osc_freq_o,
  output logic [5:0] fast_osc_trim_o,
  // crystal out pin
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic crystal_out_pin_o,
  output logic crystal_out_pin_oe_o,
  // system clock
  output logic sys_clk_lvl_o,
  output logic sys_hold_o,
  output logic lf_tick_o,
  output clkss_pkg::clkss_src_t current_source_o,
  output logic [3:0] current_divider_o
);
  typedef struct packed {
    clkss_pkg::clkss_src_t req_src;
    logic [3:0] req_div;
    logic [3:0] cur_div;
    logic hold;
    logic nsr;
    logic osc_ready_flag;
    logic swif;
    logic [2:0] frq;
    logic [5:0] trim;
    logic [3:0] men;
    clkss_pkg::clkss_sw_t fsm;
    logic go;
    logic [clkss_pkg::DATA_W-1:0] rdata;
    clkss_pkg::clkss_osc_en_t en;
    logic [1:0] gain;
    logic xout;
    logic xoe;
    logic [clkss_pkg::PS_W-1:0] pscnt;
    logic prev_lvl;
    logic sys_lvl;
    logic sys_hold;
    logic lf_tick;
  } clkss_top_st_t;

  clkss_top_st_t st_reg;
  clkss_top_st_t st_next;
  clkss_pkg::clkss_src_t rst_src;
  clkss_pkg::clkss_src_t cur_src;
  logic mux_done;
  logic mux_lvl;
  logic ost_done;
  logic ext_xtal;
  logic ext_ok;
  logic req_rdy;
  logic frq_ok;
  logic ext_cur;

  // ****************************************
  // helpers
  // ****************************************
  function automatic clkss_pkg::clkss_src_t remap(input logic [2:0] code);
    clkss_pkg::clkss_src_t s;
    s = clkss_pkg::clkss_src_t'(code);
    if (s == clkss_pkg::SRC_RSV1 || s == clkss_pkg::SRC_RSV3) begin
      s = clkss_pkg::SRC_HF;
    end
    return s;
  endfunction

  function automatic logic [3:0] clamp_div(input logic [3:0] d);
    return (d > clkss_pkg::DIV_MAX) ? clkss_pkg::DIV_MAX : d;
  endfunction

  assign rst_src = remap(reset_source_select_i);
  assign ext_xtal = clkss_pkg::clkss_xmode_t'(crystal_mode_i) != clkss_pkg::XM_EC;
  assign ext_ok = osc_ready_i[clkss_pkg::RDY_EXT] && (!ext_xtal || ost_done);
  assign frq_ok = st_reg.frq == clkss_pkg::FRQ_8M || st_reg.frq == clkss_pkg::FRQ_12M
    || st_reg.frq == clkss_pkg::FRQ_16M;
  assign ext_cur = cur_src == clkss_pkg::SRC_EXT || cur_src == clkss_pkg::SRC_EXT4X;

  // ready of requested source
  always_comb begin
    case (st_reg.req_src)
      clkss_pkg::SRC_HF2X: req_rdy = osc_ready_i[clkss_pkg::RDY_HF]
        && osc_ready_i[clkss_pkg::RDY_PLL] && frq_ok;
      clkss_pkg::SRC_EXT4X: req_rdy = ext_ok && osc_ready_i[clkss_pkg::RDY_PLL];
      clkss_pkg::SRC_SECONDARY_OSC: req_rdy = osc_ready_i[clkss_pkg::RDY_SECONDARY_OSC];
      clkss_pkg::SRC_LF: req_rdy = osc_ready_i[clkss_pkg::RDY_LF];
      clkss_pkg::SRC_HF: req_rdy = osc_ready_i[clkss_pkg::RDY_HF];
      clkss_pkg::SRC_EXT: req_rdy = ext_ok;
      default: req_rdy = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic same;
    logic use_ext;
    st_next = st_reg;
    same = st_reg.req_src == cur_src && st_reg.req_div == st_reg.cur_div;
    use_ext = 1'b0;
    st_next.rdata = '0;
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        clkss_pkg::REG_REQ: begin
          st_next.req_src = remap(reg_wdata_i[clkss_pkg::SRC_LSB+:3]);
          st_next.req_div = clamp_div(reg_wdata_i[3:0]);
        end
        clkss_pkg::REG_CTRL: begin
          st_next.hold = reg_wdata_i[clkss_pkg::CTL_HOLD];
          st_next.swif = st_reg.swif && reg_wdata_i[clkss_pkg::CTL_SWIF];
        end
        clkss_pkg::REG_FRQ: st_next.frq = reg_wdata_i[2:0];
        clkss_pkg::REG_TRIM: st_next.trim = reg_wdata_i[5:0];
        clkss_pkg::REG_MEN: st_next.men = reg_wdata_i[3:0];
        default: st_next.men = st_reg.men;
      endcase
    end
    // register reads
    if (reg_rd_i) begin
      case (reg_addr_i)
        clkss_pkg::REG_REQ: st_next.rdata = {1'b0, st_reg.req_src, st_reg.req_div};
        clkss_pkg::REG_CUR: st_next.rdata = {1'b0, cur_src, st_reg.cur_div};
        clkss_pkg::REG_CTRL: st_next.rdata = {4'h0, st_reg.swif, st_reg.osc_ready_flag, st_reg.nsr,
          st_reg.hold};
        clkss_pkg::REG_RDY: st_next.rdata = {3'h0, osc_ready_i[clkss_pkg::RDY_PLL],
          osc_ready_i[clkss_pkg::RDY_SECONDARY_OSC], osc_ready_i[clkss_pkg::RDY_LF],
          osc_ready_i[clkss_pkg::RDY_HF], ext_ok};
        clkss_pkg::REG_FRQ: st_next.rdata = {5'h00, st_reg.frq};
        clkss_pkg::REG_TRIM: st_next.rdata = {2'h0, st_reg.trim};
        clkss_pkg::REG_MEN: st_next.rdata = {4'h0, st_reg.men};
        default: st_next.rdata = '0;
      endcase
    end
    // switch sequence
    st_next.go = 1'b0;
    case (st_reg.fsm)
      clkss_pkg::SW_IDLE: begin
        if (!same) begin
          st_next.fsm = clkss_pkg::SW_WAIT;
          st_next.osc_ready_flag = 1'b0;
        end
      end
      clkss_pkg::SW_WAIT: begin
        if (same) begin
          st_next.fsm = clkss_pkg::SW_IDLE;
          st_next.osc_ready_flag = 1'b1;
        end else if (req_rdy) begin
          st_next.nsr = 1'b1;
          st_next.swif = 1'b1;
          if (st_reg.hold) begin
            st_next.fsm = clkss_pkg::SW_HOLD;
          end else begin
            st_next.fsm = clkss_pkg::SW_SWITCH;
            st_next.go = 1'b1;
          end
        end
      end
      clkss_pkg::SW_HOLD: begin
        if (same) begin
          st_next.fsm = clkss_pkg::SW_IDLE;
          st_next.nsr = 1'b0;
          st_next.osc_ready_flag = 1'b1;
        end else if (!req_rdy) begin
          st_next.fsm = clkss_pkg::SW_WAIT;
          st_next.nsr = 1'b0;
        end else if (!st_reg.hold) begin
          st_next.fsm = clkss_pkg::SW_SWITCH;
          st_next.go = 1'b1;
        end
      end
      clkss_pkg::SW_SWITCH: begin
        st_next.go = !mux_done;
        if (mux_done) begin
          st_next.fsm = clkss_pkg::SW_IDLE;
          st_next.cur_div = st_reg.req_div;
          st_next.osc_ready_flag = 1'b1;
          st_next.nsr = 1'b0;
        end
      end
      default: st_next.fsm = clkss_pkg::SW_IDLE;
    endcase
    // oscillator enables
    use_ext = cur_src == clkss_pkg::SRC_EXT || cur_src == clkss_pkg::SRC_EXT4X
      || st_reg.req_src == clkss_pkg::SRC_EXT || st_reg.req_src == clkss_pkg::SRC_EXT4X;
    st_next.en.ext = use_ext || st_reg.men[clkss_pkg::RDY_EXT];
    st_next.en.hf = st_reg.men[clkss_pkg::RDY_HF] || cur_src == clkss_pkg::SRC_HF
      || st_reg.req_src == clkss_pkg::SRC_HF || cur_src == clkss_pkg::SRC_HF2X
      || st_reg.req_src == clkss_pkg::SRC_HF2X;
    st_next.en.lf = 1'b1;
    st_next.en.secondary_osc = st_reg.men[clkss_pkg::RDY_SECONDARY_OSC] || cur_src == clkss_pkg::SRC_SECONDARY_OSC
      || st_reg.req_src == clkss_pkg::SRC_SECONDARY_OSC;
    st_next.en.pll4x = cur_src == clkss_pkg::SRC_EXT4X
      || st_reg.req_src == clkss_pkg::SRC_EXT4X;
    st_next.en.pll2x = (cur_src == clkss_pkg::SRC_HF2X
      || st_reg.req_src == clkss_pkg::SRC_HF2X) && frq_ok;
    st_next.gain = ext_xtal && use_ext ? crystal_mode_i : clkss_pkg::XM_EC;
    // postscaler on the selected source
    st_next.prev_lvl = mux_lvl;
    if (mux_lvl && !st_reg.prev_lvl) begin
      st_next.pscnt = st_reg.pscnt + 1'b1;
    end
    if (st_reg.cur_div == clkss_pkg::DIV_RST_DEF) begin
      st_next.sys_lvl = mux_lvl;
    end else begin
      st_next.sys_lvl = st_reg.pscnt[st_reg.cur_div - clkss_pkg::DIV_ONE];
    end
    st_next.sys_hold = ext_cur && ext_xtal && !ost_done;
    st_next.lf_tick = src_clk_lvl_i[clkss_pkg::SRC_LF];
    // crystal out pin
    st_next.xout = clock_out_pin_enable_i ? st_reg.sys_lvl : gpio_out_i;
    st_next.xoe = clock_out_pin_enable_i || gpio_oe_i;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
      st_reg.req_src <= rst_src;
      st_reg.req_div <= (rst_src == clkss_pkg::SRC_HF) ? clkss_pkg::DIV_RST_HF
        : clkss_pkg::DIV_RST_DEF;
      st_reg.cur_div <= (rst_src == clkss_pkg::SRC_HF) ? clkss_pkg::DIV_RST_HF
        : clkss_pkg::DIV_RST_DEF;
      st_reg.frq <= (rst_src == clkss_pkg::SRC_HF2X) ? clkss_pkg::FRQ_16M
        : clkss_pkg::FRQ_RST_DEF;
      st_reg.trim <= clkss_pkg::TRIM_RST;
      st_reg.osc_ready_flag <= 1'b1;
      st_reg.fsm <= clkss_pkg::SW_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // submodules
  // ****************************************
  clkss_startup u_startup (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .restart_i(wake_i),
    .run_i(ext_xtal && st_reg.en.ext),
    .xtal_lvl_i(crystal_in_pin_i),
    .done_o(ost_done)
  );

  clkss_glitchless u_mux (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rst_sel_i(rst_src),
    .req_sel_i(st_reg.req_src),
    .go_i(st_reg.go),
    .src_lvl_i(src_clk_lvl_i),
    .cur_sel_o(cur_src),
    .done_o(mux_done),
    .clk_lvl_o(mux_lvl)
  );

  assign reg_rdata_o = st_reg.rdata;
  assign osc_enable_o = st_reg.en;
  assign gain_select_o = st_reg.gain;
  assign fast_osc_freq_o = st_reg.frq;
  assign fast_osc_trim_o = st_reg.trim;
  assign crystal_out_pin_o = st_reg.xout;
  assign crystal_out_pin_oe_o = st_reg.xoe;
  assign sys_clk_lvl_o = st_reg.sys_lvl;
  assign sys_hold_o = st_reg.sys_hold;
  assign lf_tick_o = st_reg.lf_tick;
  assign current_source_o = cur_src;
  assign current_divider_o = st_reg.cur_div;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence req_seen_s;
    st_reg.fsm == clkss_pkg::SW_WAIT && req_rdy && !st_reg.hold
      && !(st_reg.req_src == cur_src && st_reg.req_div == st_reg.cur_div);
  endsequence
  sequence flags_set_s;
    st_reg.nsr && st_reg.swif && st_reg.fsm == clkss_pkg::SW_SWITCH;
  endsequence

  ost_hold_a: assert property (ext_cur && ext_xtal && !ost_done |=> sys_hold_o)
    else $error("system clock not held during start-up");
  pll_range_a: assert property (osc_enable_o.pll2x |-> $past(frq_ok))
    else $error("doubling PLL enabled outside its input range");
  reset_frq_a: assert property (@(posedge sys_clk_i) $past(reset_i)
    && $past(reset_source_select_i) == clkss_pkg::SRC_HF2X |-> fast_osc_freq_o == clkss_pkg::FRQ_16M)
    else $error("reset frequency select wrong");
  switch_flags_a: assert property (req_seen_s |=> flags_set_s)
    else $error("ready flags not set on new source ready");
  hold_keep_a: assert property (st_reg.fsm == clkss_pkg::SW_HOLD && st_reg.hold
    |=> $stable(current_source_o) [*2])
    else $error("clock changed while switch held");
  switch_done_a: assert property (mux_done |=> st_reg.osc_ready_flag && !st_reg.nsr
    && current_divider_o == $past(st_reg.req_div))
    else $error("switch completion state wrong");
  reserved_a: assert property (reg_wr_i && reg_addr_i == clkss_pkg::REG_REQ
    && reg_wdata_i[clkss_pkg::SRC_LSB] && !reg_wdata_i[clkss_pkg::SRC_LSB+2]
    |=> st_reg.req_src == clkss_pkg::SRC_HF)
    else $error("reserved source code not remapped");
  trim_no_flag_a: assert property (reg_wr_i && reg_addr_i == clkss_pkg::REG_TRIM
    && st_reg.fsm == clkss_pkg::SW_IDLE
    |=> fast_osc_trim_o == $past(reg_wdata_i[5:0]) && $stable(st_reg.swif))
    else $error("trim write misbehaved");
endmodule // clkss_top

// ===== testbench/clkss_osc_model.sv
// clkss_osc_model: oscillators, crystal and source clocks behind the block
`timescale 1ns/1ns
module clkss_osc_model (
  // clock
  input wire logic sys_clk_i,
  // enables from the block
  input wire clkss_pkg::clkss_osc_en_t osc_enable_i,
  // oscillator side
  output logic [4:0] osc_ready_o,
  output logic [7:0] src_clk_lvl_o,
  output logic crystal_in_pin_o
);
  // ****************************************
  // start-up and clocks
  // ****************************************
  logic [7:0] cnt_reg = 8'h00;
  logic [4:0] en;
  logic [5:0] age[5] = '{default: 6'h00};
  assign en = {osc_enable_i.pll4x | osc_enable_i.pll2x, osc_enable_i.secondary_osc, osc_enable_i.lf,
    osc_enable_i.hf, osc_enable_i.ext};
  assign src_clk_lvl_o = {cnt_reg[2:0], cnt_reg[2:0], cnt_reg[1:0]};
  // crystal toggles only while its amplifier is on
  assign crystal_in_pin_o = osc_enable_i.ext & cnt_reg[0];
  always @(posedge sys_clk_i) begin
    cnt_reg <= cnt_reg + 8'h01;
    for (int i = 0; i < 5; i++) begin
      age[i] <= !en[i] ? 6'h00 : (age[i] == 6'h08 ? age[i] : age[i] + 6'h01);
      osc_ready_o[i] <= en[i] && age[i] == 6'h08;
    end
  end
endmodule // clkss_osc_model

// ===== testbench/tb_top.sv
// tb_top: self-checking bench of the clock source select block
`timescale 1ns/1ns
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [2:0] reset_source_select_i = 3'h6;
  logic [1:0] crystal_mode_i = 2'h2;
  logic clock_out_pin_enable_i = 1'b0;
  logic wake_i = 1'b0;
  logic gpio_out_i = 1'b0;
  logic gpio_oe_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [4:0] osc_ready_i;
  logic [7:0] src_clk_lvl_i;
  logic crystal_in_pin_i;
  clkss_pkg::clkss_osc_en_t osc_enable_o;
  logic [1:0] gain_select_o;
  logic [2:0] fast_osc_freq_o;
  logic [5:0] fast_osc_trim_o;
  logic crystal_out_pin_o;
  logic crystal_out_pin_oe_o;
  logic sys_clk_lvl_o;
  logic sys_hold_o;
  logic lf_tick_o;
  clkss_pkg::clkss_src_t current_source_o;
  logic [3:0] current_divider_o;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int n;
  logic [7:0] t;
  logic [3:0] d;

  always #5 sys_clk_i = ~sys_clk_i;

  clkss_top i_clkss_top (
    .sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reset_source_select_i, .crystal_mode_i, .clock_out_pin_enable_i, .wake_i,
    .osc_ready_i, .src_clk_lvl_i, .crystal_in_pin_i, .osc_enable_o, .gain_select_o,
    .fast_osc_freq_o, .fast_osc_trim_o, .gpio_out_i, .gpio_oe_i, .crystal_out_pin_o,
    .crystal_out_pin_oe_o, .sys_clk_lvl_o, .sys_hold_o, .lf_tick_o,
    .current_source_o, .current_divider_o
  );
  clkss_osc_model i_clkss_osc_model (
    .sys_clk_i, .osc_enable_i(osc_enable_o), .osc_ready_o(osc_ready_i),
    .src_clk_lvl_o(src_clk_lvl_i), .crystal_in_pin_o(crystal_in_pin_i)
  );

  // ****************************************
  // tasks and read monitor
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, ex);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic wait_cur(input logic [6:0] tg, output int c);
    c = 0;
    while ({current_source_o, current_divider_o} !== tg && c < 4000) begin
      @(posedge sys_clk_i);
      c++;
    end
    if (c == 4000) begin
      n_errors++;
      finish_test();
    end
  endtask
  always @(posedge sys_clk_i) rd_seen <= reg_rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(reg_rdata_o, exp_q.pop_front());
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    n = $urandom(66);
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(clkss_pkg::REG_REQ, 8'h62);
    rd(clkss_pkg::REG_CUR, 8'h62);
    rd(clkss_pkg::REG_FRQ, 8'h03);
    rd(clkss_pkg::REG_TRIM, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'hF, 8'hFF);
    rd(clkss_pkg::REG_CTRL, 8'h04);
    $display("test reset done");
    wr(clkss_pkg::REG_REQ, 8'h70);
    wait_cur(7'h70, n);
    chk(n >= 2000, 1);
    chk(gain_select_o, crystal_mode_i);
    $display("test crystal done");
    wr(clkss_pkg::REG_FRQ, 8'h06);
    @(negedge sys_clk_i);
    chk(fast_osc_freq_o, 3'h6);
    for (int s = 0; s < 8; s++) begin
      d = 4'($urandom_range(9));
      wr(clkss_pkg::REG_REQ, {1'b0, 3'(s), d});
      t[2:0] = (s == 1 || s == 3) ? 3'h6 : 3'(s);
      wait_cur({t[2:0], d}, n);
      rd(clkss_pkg::REG_CUR, {1'b0, t[2:0], d});
      chk(osc_enable_o.pll2x, s == 0);
      chk(osc_enable_o.pll4x, s == 2);
    end
    wake_i <= 1'b1;
    @(posedge sys_clk_i);
    wake_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(sys_hold_o, 1);
    wr(clkss_pkg::REG_REQ, 8'h6F);
    wait_cur(7'h69, n);
    $display("test switch done");
    wr(clkss_pkg::REG_CTRL, 8'h01);
    wr(clkss_pkg::REG_REQ, 8'h50);
    n = 0;
    repeat (100) begin
      @(posedge sys_clk_i);
      if (current_source_o !== clkss_pkg::SRC_HF) n++;
    end
    chk(n, 0);
    rd(clkss_pkg::REG_CTRL, 8'h0B);
    wr(clkss_pkg::REG_CTRL, 8'h00);
    wait_cur(7'h50, n);
    rd(clkss_pkg::REG_CTRL, 8'h04);
    wr(clkss_pkg::REG_CTRL, 8'h01);
    wr(clkss_pkg::REG_REQ, 8'h60);
    repeat (20) @(posedge sys_clk_i);
    rd(clkss_pkg::REG_CTRL, 8'h0B);
    wr(clkss_pkg::REG_REQ, 8'h50);
    wr(clkss_pkg::REG_CTRL, 8'h00);
    rd(clkss_pkg::REG_CUR, 8'h50);
    $display("test hold done");
    for (int i = 0; i < 3; i++) begin
      t = (i == 0) ? 8'h3F : (i == 1) ? 8'h00 : 8'($urandom_range(63));
      wr(clkss_pkg::REG_TRIM, t);
      rd(clkss_pkg::REG_TRIM, t);
      chk(fast_osc_trim_o, t[5:0]);
    end
    rd(clkss_pkg::REG_CTRL, 8'h04);
    @(negedge sys_clk_i);
    t[0] = src_clk_lvl_i[clkss_pkg::SRC_LF];
    @(negedge sys_clk_i);
    chk(lf_tick_o, t[0]);
    wr(clkss_pkg::REG_MEN, 8'h08);
    repeat (2) @(negedge sys_clk_i);
    chk(osc_enable_o.secondary_osc, 1);
    rd(clkss_pkg::REG_CUR, 8'h50);
    wr(clkss_pkg::REG_MEN, 8'h00);
    gpio_oe_i <= 1'b1;
    gpio_out_i <= 1'($urandom);
    repeat (3) @(negedge sys_clk_i);
    chk({crystal_out_pin_oe_o, crystal_out_pin_o}, {1'b1, gpio_out_i});
    clock_out_pin_enable_i <= 1'b1;
    wr(clkss_pkg::REG_REQ, 8'h53);
    wait_cur(7'h53, n);
    repeat (4) @(negedge sys_clk_i);
    t = 8'h00;
    d[1:0] = {sys_clk_lvl_o, crystal_out_pin_o};
    repeat (160) begin
      @(negedge sys_clk_i);
      t[3:0] += 4'(sys_clk_lvl_o && !d[1]);
      t[7:4] += 4'(crystal_out_pin_o && !d[0]);
      d[1:0] = {sys_clk_lvl_o, crystal_out_pin_o};
    end
    chk(t, 8'hAA);
    chk(crystal_out_pin_oe_o, 1);
    $display("test trim and pins done");
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    reset_source_select_i <= 3'h0;
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(clkss_pkg::REG_CUR, 8'h00);
    rd(clkss_pkg::REG_FRQ, 8'h06);
    chk(osc_enable_o.pll2x, 1);
    $display("test second reset done");
    repeat (2) @(posedge sys_clk_i);
    finish_test();
  end
endmodule // tb_top
